// file: dmacs_regs.sv
`timescale 1ns/1ps
module dmacs_regs
(
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [11:0] busErr, // bus error per channel
    input wire logic [11:0] badDesc, // invalid descriptor fetched
    input wire logic [11:0] blockEnd, // block completed
    input wire logic [11:0] blockIrq, // block action has interrupt
    input wire logic [11:0] blockSusp, // block action is suspend
    input wire logic [11:0] cmdSusp, // software suspend command
    input wire logic [11:0] evSusp, // suspend event
    input wire logic [11:0] zeroCount, // remaining beat count is zero
    input wire logic [11:0] chBusy, // channel busy
    input wire logic [11:0] chPend, // channel pending
    input wire logic [11:0] chFetchErr, // fetch error per channel
    output logic [11:0] descValidClr, // clear descriptor valid bit
    output logic [11:0] writeBack, // write descriptor back
    output logic [11:0] swTrigger, // software triggers
    output logic controllerEnable, // controller enable
    output logic [3:0] levelEnable, // priority level enables
    output logic [31:0] levelPriority, // priority control
    output logic [5:0] serviceLevels, // qos fields
    output logic runWhileHalted, // debug run
    output logic irq // interrupt request
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] crc_control;
        logic [7:0] dbg;
        logic [7:0] qos;
        logic [11:0] swTrig;
        logic [31:0] pri;
        logic [3:0] chSel;
        logic [11:0] errEn;
        logic [11:0] doneEn;
        logic [11:0] suspEn;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic [11:0] vclr;
        logic [11:0] wb;
        logic irq;
    } dmacs_regs_t;
    dmacs_regs_t st_r;
    dmacs_regs_t st_nxt;

    dmacs_flag_if fl ();
    logic [31:0] crcSum;
    logic checksum_busy;
    logic crcDataWr;
    logic crcSumWr;
    logic softRst;
    logic setup;
    logic wrEn;
    logic [7:0] idx;
    logic [3:0] pendId;
    logic [11:0] chIrq;

    assign setup = psel && !penable;
    assign idx = paddr[9:2];
    assign wrEn = setup && pwrite && (paddr[1:0] == 2'b00);
    assign softRst = st_r.ctrl[dmacs_pkg::CTRL_SOFT_RESET];
    assign crcDataWr = wrEn && idx == dmacs_pkg::IDX_CRCDATA;
    assign crcSumWr = wrEn && idx == dmacs_pkg::IDX_CRCSUM;

    assign fl.setErr = busErr | badDesc;
    assign fl.setDone = blockEnd & blockIrq;
    assign fl.setSusp = (blockEnd & blockSusp) | cmdSusp | evSusp | badDesc;
    assign fl.chSel = st_r.chSel;
    assign fl.clrBits = (wrEn && idx == dmacs_pkg::IDX_CHFLAG) ? pwdata[2:0] : dmacs_pkg::FLG_NONE;
    assign chIrq = (fl.errFlag & st_r.errEn) | (fl.doneFlag & st_r.doneEn)
        | (fl.suspFlag & st_r.suspEn);

    always_comb
    begin
        pendId = 4'h0;
        for (int i = dmacs_pkg::NUM_CH - 1; i >= 0; i--)
            if (chIrq[i]) pendId = 4'(i);
    end

    dmacs_flag_bank u_flags
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .softRst(softRst),
        .fl(fl.bank)
    );

    dmacs_crc_unit u_crc
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .softRst(softRst),
        .enable(st_r.ctrl[dmacs_pkg::CTRL_CRCEN]),
        .poly(st_r.crc_control[3:2]),
        .dataWr(crcDataWr),
        .dataIn(pwdata),
        .sumWr(crcSumWr),
        .sumIn(pwdata),
        .checksum(crcSum),
        .busy(checksum_busy)
    );

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ready = setup;
        st_nxt.slverr = 1'b0;
        st_nxt.rdata = dmacs_pkg::ZERO32;
        st_nxt.swTrig = '0;
        st_nxt.vclr = zeroCount & blockEnd;
        st_nxt.wb = st_r.vclr;
        st_nxt.irq = |chIrq;
        if (setup && pwrite && wrEn)
        begin
            case (idx)
                dmacs_pkg::IDX_CTRL: st_nxt.ctrl = pwdata[15:0] & dmacs_pkg::CTRL_MASK;
                dmacs_pkg::IDX_CRC_CONTROL: st_nxt.crc_control = pwdata[15:0] & dmacs_pkg::CRC_CONTROL_MASK;
                dmacs_pkg::IDX_CRCDATA, dmacs_pkg::IDX_CRCSUM, dmacs_pkg::IDX_CHFLAG: ;
                dmacs_pkg::IDX_DEBUG_RUN_CONTROL: st_nxt.dbg = {7'h00, pwdata[0]};
                dmacs_pkg::IDX_SERVICE_LEVEL_CONTROL: st_nxt.qos = pwdata[7:0] & dmacs_pkg::QOS_MASK;
                dmacs_pkg::IDX_SWTRIG: st_nxt.swTrig = pwdata[11:0];
                dmacs_pkg::IDX_PRICTRL: st_nxt.pri = pwdata & dmacs_pkg::PRI_MASK;
                dmacs_pkg::IDX_CHSEL: st_nxt.chSel = pwdata[3:0];
                dmacs_pkg::IDX_CHINTEN:
                begin
                    // one writes set enables of the selected channel
                    if (st_r.chSel < 4'(dmacs_pkg::NUM_CH))
                    begin
                        if (pwdata[dmacs_pkg::FLG_TRANSFER_ERROR_FLAG]) st_nxt.errEn[st_r.chSel] = 1'b1;
                        if (pwdata[dmacs_pkg::FLG_TRANSFER_DONE_FLAG]) st_nxt.doneEn[st_r.chSel] = 1'b1;
                        if (pwdata[dmacs_pkg::FLG_SUSPEND_FLAG]) st_nxt.suspEn[st_r.chSel] = 1'b1;
                    end
                end
                default: st_nxt.slverr = 1'b1;
            endcase
        end
        else if (setup && (pwrite || paddr[1:0] != 2'b00))
            st_nxt.slverr = 1'b1;
        else if (setup)
        begin
            case (idx)
                dmacs_pkg::IDX_CTRL: st_nxt.rdata = {16'h0000, st_r.ctrl};
                dmacs_pkg::IDX_CRC_CONTROL: st_nxt.rdata = {16'h0000, st_r.crc_control};
                dmacs_pkg::IDX_CRCDATA: st_nxt.rdata = dmacs_pkg::ZERO32;
                dmacs_pkg::IDX_CRCSUM: st_nxt.rdata = crcSum;
                dmacs_pkg::IDX_CRCSTAT: st_nxt.rdata = {30'h00000000, crcSum == dmacs_pkg::ZERO32, checksum_busy};
                dmacs_pkg::IDX_DEBUG_RUN_CONTROL: st_nxt.rdata = {24'h000000, st_r.dbg};
                dmacs_pkg::IDX_SERVICE_LEVEL_CONTROL: st_nxt.rdata = {24'h000000, st_r.qos};
                dmacs_pkg::IDX_SWTRIG: st_nxt.rdata = {20'h00000, st_r.swTrig};
                dmacs_pkg::IDX_PRICTRL: st_nxt.rdata = st_r.pri;
                dmacs_pkg::IDX_PENDING_INTERRUPT_INFO: st_nxt.rdata = {16'h0000, 1'b0, 1'b0, 1'b0, 2'b00,
                    fl.suspFlag[pendId], fl.doneFlag[pendId], fl.errFlag[pendId], 4'h0, pendId}
                    | {16'h0000, chPend[pendId], chBusy[pendId], chFetchErr[pendId], 13'h0000};
                dmacs_pkg::IDX_INTSTAT: st_nxt.rdata = {20'h00000, chIrq};
                dmacs_pkg::IDX_BUSY_CHANNELS: st_nxt.rdata = {20'h00000, chBusy};
                dmacs_pkg::IDX_PENDING_CHANNELS: st_nxt.rdata = {20'h00000, chPend};
                dmacs_pkg::IDX_CHSEL: st_nxt.rdata = {28'h0000000, st_r.chSel};
                dmacs_pkg::IDX_CHINTEN: st_nxt.rdata = (st_r.chSel < 4'(dmacs_pkg::NUM_CH)) ?
                    {29'h00000000, st_r.suspEn[st_r.chSel], st_r.doneEn[st_r.chSel],
                    st_r.errEn[st_r.chSel]} : dmacs_pkg::ZERO32;
                dmacs_pkg::IDX_CHFLAG: st_nxt.rdata = {29'h00000000, fl.selFlags};
                default: st_nxt.slverr = 1'b1;
            endcase
        end
        if (softRst)
        begin
            // soft reset returns all registers and clears itself
            st_nxt.ctrl = '0;
            st_nxt.crc_control = '0;
            st_nxt.dbg = '0;
            st_nxt.qos = dmacs_pkg::QOS_RST;
            st_nxt.pri = '0;
            st_nxt.chSel = '0;
            st_nxt.errEn = '0;
            st_nxt.doneEn = '0;
            st_nxt.suspEn = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n) st_r <= '0;
        else st_r <= st_nxt;
    end

    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.slverr;
    assign descValidClr = st_r.vclr;
    assign writeBack = st_r.wb;
    assign swTrigger = st_r.swTrig;
    assign controllerEnable = st_r.ctrl[dmacs_pkg::CTRL_EN];
    assign levelEnable = st_r.ctrl[dmacs_pkg::CTRL_LVL_LSB +: dmacs_pkg::NUM_LVL];
    assign levelPriority = st_r.pri;
    assign serviceLevels = st_r.qos[5:0];
    assign runWhileHalted = st_r.dbg[0];
    assign irq = st_r.irq;

    chk_irq_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|chIrq) |=> irq) else $error("irq missing for enabled flag");
    chk_irq_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(|chIrq) |=> !irq) else $error("irq without enabled flag");
    chk_valid_before_wb: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (blockEnd[3] && zeroCount[3]) |=> descValidClr[3] ##1 writeBack[3])
        else $error("valid not cleared before write-back");
    chk_done_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|fl.setDone && !softRst) |=> (fl.doneFlag & $past(fl.setDone)) == $past(fl.setDone))
        else $error("done flag not set");
    chk_suspend_flag_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|cmdSusp && !softRst) |=> (fl.suspFlag & $past(cmdSusp)) == $past(cmdSusp))
        else $error("suspend flag not set");
    chk_zero_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wrEn && idx == dmacs_pkg::IDX_CHFLAG && pwdata[2:0] == 3'h0 && !softRst
        && fl.selFlags[dmacs_pkg::FLG_TRANSFER_ERROR_FLAG]) |=> fl.selFlags[dmacs_pkg::FLG_TRANSFER_ERROR_FLAG])
        else $error("zero write cleared flag");
    chk_enable_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wrEn && idx == dmacs_pkg::IDX_CHINTEN && pwdata[0]
        && st_r.chSel < 4'(dmacs_pkg::NUM_CH) && !softRst)
        |=> st_r.errEn[$past(st_r.chSel)]) else $error("error enable not set");
    chk_trig_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|swTrigger) |=> !(|swTrigger) || $past(wrEn)) else $error("trigger stuck");
    chk_ready_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setup |=> pready) else $error("no ready after setup");
    cov_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq));
    cov_clear: cover property (@(posedge ref_clk) disable iff (!rst_n)
        wrEn && idx == dmacs_pkg::IDX_CHFLAG && |pwdata[2:0]);
    cov_wb: cover property (@(posedge ref_clk) disable iff (!rst_n) |writeBack);
endmodule

// file: dmacs_pkg.sv
package dmacs_pkg;
    localparam int NUM_CH = 12;
    localparam int NUM_LVL = 4;
    // word indices (some printed offsets are not word aligned: kept as index)
    localparam logic [7:0] IDX_CTRL = 8'h00;
    localparam logic [7:0] IDX_CRC_CONTROL = 8'h02;
    localparam logic [7:0] IDX_CRCDATA = 8'h04;
    localparam logic [7:0] IDX_CRCSUM = 8'h08;
    localparam logic [7:0] IDX_CRCSTAT = 8'h0C;
    localparam logic [7:0] IDX_DEBUG_RUN_CONTROL = 8'h0D;
    localparam logic [7:0] IDX_SERVICE_LEVEL_CONTROL = 8'h0E;
    localparam logic [7:0] IDX_SWTRIG = 8'h10;
    localparam logic [7:0] IDX_PRICTRL = 8'h14;
    localparam logic [7:0] IDX_PENDING_INTERRUPT_INFO = 8'h20;
    localparam logic [7:0] IDX_INTSTAT = 8'h24;
    localparam logic [7:0] IDX_BUSY_CHANNELS = 8'h28;
    localparam logic [7:0] IDX_PENDING_CHANNELS = 8'h2C;
    localparam logic [7:0] IDX_CHSEL = 8'h3F;
    localparam logic [7:0] IDX_CHINTEN = 8'h4D;
    localparam logic [7:0] IDX_CHFLAG = 8'h4E;
    // field positions
    localparam int CTRL_SOFT_RESET = 0;
    localparam int CTRL_EN = 1;
    localparam int CTRL_CRCEN = 2;
    localparam int CTRL_LVL_LSB = 8;
    localparam int CRC_SRC_LSB = 8;
    localparam int FLG_TRANSFER_ERROR_FLAG = 0;
    localparam int FLG_TRANSFER_DONE_FLAG = 1;
    localparam int FLG_SUSPEND_FLAG = 2;
    localparam int PENDING_INDICATION_TRANSFER_ERROR_FLAG = 8;
    localparam int PENDING_INDICATION_FETCH_ERROR_INDICATION = 13;
    localparam int PENDING_INDICATION_BUSY = 14;
    localparam int PENDING_INDICATION_PENDING_INDICATION = 15;
    localparam int PRI_RR = 7;
    // write masks and resets
    localparam logic [15:0] CTRL_MASK = 16'h0F07;
    localparam logic [15:0] CRC_CONTROL_MASK = 16'h3F0F;
    localparam logic [7:0] QOS_MASK = 8'h3F;
    localparam logic [31:0] PRI_MASK = 32'h8F8F8F8F;
    localparam logic [7:0] QOS_RST = 8'h00;
    localparam logic [31:0] ZERO32 = 32'h00000000;
    localparam logic [2:0] FLG_NONE = 3'h0;
endpackage

// file: dmacs_flag_if.sv
`timescale 1ns/1ps
interface dmacs_flag_if;
    logic [11:0] setErr;
    logic [11:0] setDone;
    logic [11:0] setSusp;
    logic [3:0] chSel;
    logic [2:0] clrBits;
    logic [2:0] selFlags;
    logic [11:0] anyFlag;
    logic [11:0] errFlag;
    logic [11:0] doneFlag;
    logic [11:0] suspFlag;
    modport ctl (output setErr, setDone, setSusp, chSel, clrBits,
        input selFlags, anyFlag, errFlag, doneFlag, suspFlag);
    modport bank (input setErr, setDone, setSusp, chSel, clrBits,
        output selFlags, anyFlag, errFlag, doneFlag, suspFlag);
endinterface

// file: dmacs_flag_bank.sv
`timescale 1ns/1ps
module dmacs_flag_bank
(
    input wire logic ref_clk, // clock
    input wire logic rst_n, // async reset
    input wire logic softRst, // soft reset
    dmacs_flag_if.bank fl // flag port
);
    typedef struct packed {
        logic [11:0] err;
        logic [11:0] done;
        logic [11:0] suspend_flag;
    } dmacs_bank_t;
    dmacs_bank_t st_r;
    dmacs_bank_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        for (int i = 0; i < dmacs_pkg::NUM_CH; i++)
        begin
            // clear only the selected channel, set wins
            if (fl.chSel == 4'(i))
            begin
                if (fl.clrBits[dmacs_pkg::FLG_TRANSFER_ERROR_FLAG]) st_nxt.err[i] = 1'b0;
                if (fl.clrBits[dmacs_pkg::FLG_TRANSFER_DONE_FLAG]) st_nxt.done[i] = 1'b0;
                if (fl.clrBits[dmacs_pkg::FLG_SUSPEND_FLAG]) st_nxt.suspend_flag[i] = 1'b0;
            end
            if (fl.setErr[i]) st_nxt.err[i] = 1'b1;
            if (fl.setDone[i]) st_nxt.done[i] = 1'b1;
            if (fl.setSusp[i]) st_nxt.suspend_flag[i] = 1'b1;
        end
        if (softRst) st_nxt = '0;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n) st_r <= '0;
        else st_r <= st_nxt;
    end

    assign fl.selFlags = (fl.chSel < 4'(dmacs_pkg::NUM_CH)) ?
        {st_r.suspend_flag[fl.chSel], st_r.done[fl.chSel], st_r.err[fl.chSel]} : dmacs_pkg::FLG_NONE;
    assign fl.anyFlag = st_r.err | st_r.done | st_r.suspend_flag;
    assign fl.errFlag = st_r.err;
    assign fl.doneFlag = st_r.done;
    assign fl.suspFlag = st_r.suspend_flag;

    chk_set_wins_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|fl.setErr && !softRst) |=> (st_r.err & $past(fl.setErr)) == $past(fl.setErr))
        else $error("error flag set lost");
    chk_clear_other_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (fl.chSel != 4'h3 && st_r.err[3] && !softRst) |=> st_r.err[3])
        else $error("flag of unselected channel cleared");
endmodule

// file: dmacs_crc_unit.sv
`timescale 1ns/1ps
module dmacs_crc_unit
(
    input wire logic ref_clk, // clock
    input wire logic rst_n, // async reset
    input wire logic softRst, // soft reset
    input wire logic enable, // checksum unit enabled
    input wire logic [1:0] poly, // 0 = crc16, 1 = crc32
    input wire logic dataWr, // data input written
    input wire logic [31:0] dataIn, // data word
    input wire logic sumWr, // checksum written
    input wire logic [31:0] sumIn, // new checksum
    output logic [31:0] checksum, // current checksum
    output logic busy // checksum busy
);
    typedef struct packed {
        logic [31:0] sum;
        logic busy;
    } dmacs_crc_t;
    dmacs_crc_t st_r;
    dmacs_crc_t st_nxt;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d,
        input logic wide);
        logic [31:0] r;
        r = c;
        for (int b = 0; b < 8; b++)
        begin
            if (wide)
                r = (r[0] ^ d[b]) ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
            else
                r = {16'h0000, (r[15] ^ d[7 - b]) ? ((r[15:0] << 1) ^ 16'h1021) : (r[15:0] << 1)};
        end
        return r;
    endfunction

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.busy = 1'b0;
        if (sumWr) st_nxt.sum = sumIn;
        else if (dataWr && enable)
        begin
            st_nxt.sum = crc_byte(crc_byte(crc_byte(crc_byte(st_r.sum, dataIn[7:0], poly[0]),
                dataIn[15:8], poly[0]), dataIn[23:16], poly[0]), dataIn[31:24], poly[0]);
            st_nxt.busy = 1'b1;
        end
        if (softRst) st_nxt = '0;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n) st_r <= '0;
        else st_r <= st_nxt;
    end

    assign checksum = st_r.sum;
    assign busy = st_r.busy;
endmodule

// file: dmacs_far_model.sv
`timescale 1ns/1ps
module dmacs_far_model
(
    input wire logic ref_clk, // clock
    input wire logic rst_n, // reset
    output logic [11:0] busErr, // bus error
    output logic [11:0] badDesc, // bad descriptor
    output logic [11:0] blockEnd, // block end
    output logic [11:0] blockIrq, // block asks interrupt
    output logic [11:0] blockSusp, // block asks suspend
    output logic [11:0] cmdSusp, // suspend command
    output logic [11:0] evSusp, // suspend event
    output logic [11:0] zeroCount, // count is zero
    output logic [11:0] chBusy, // busy levels
    output logic [11:0] chPend, // pending levels
    output logic [11:0] chFetchErr, // fetch error levels
    input wire logic [11:0] descValidClr, // valid clear
    input wire logic [11:0] writeBack, // descriptor write-back
    output logic [11:0] seenClr, // valid clears seen
    output int orderErr // write-backs out of order
);
    logic [11:0] prevClr;
    initial
    begin
        {busErr, badDesc, blockEnd, blockIrq, blockSusp, cmdSusp, evSusp, zeroCount} = '0;
        {chBusy, chPend, chFetchErr} = '0;
    end
    // one-cycle event pulse on one channel
    task fire(input logic [7:0] k, input int ch);
        @(posedge ref_clk);
        busErr <= 12'(k[0]) << ch;
        badDesc <= 12'(k[1]) << ch;
        blockEnd <= 12'(k[2]) << ch;
        blockIrq <= 12'(k[3]) << ch;
        blockSusp <= 12'(k[4]) << ch;
        cmdSusp <= 12'(k[5]) << ch;
        evSusp <= 12'(k[6]) << ch;
        zeroCount <= 12'(k[7]) << ch;
        @(posedge ref_clk);
        {busErr, badDesc, blockEnd, blockIrq, blockSusp, cmdSusp, evSusp, zeroCount} <= '0;
    endtask
    task levels(input logic [11:0] b, input logic [11:0] p, input logic [11:0] f);
        @(posedge ref_clk);
        chBusy <= b;
        chPend <= p;
        chFetchErr <= f;
    endtask
    // write-back must follow the valid clear by one cycle
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prevClr <= '0;
            seenClr <= '0;
            orderErr <= 0;
        end
        else
        begin
            prevClr <= descValidClr;
            seenClr <= seenClr | descValidClr;
            if (writeBack !== prevClr) orderErr <= orderErr + 1;
        end
    end
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, controllerEnable, runWhileHalted, irq;
    logic [11:0] busErr, badDesc, blockEnd, blockIrq, blockSusp, cmdSusp, evSusp, zeroCount;
    logic [11:0] chBusy, chPend, chFetchErr, descValidClr, writeBack, swTrigger, seenClr;
    logic [11:0] seenTrig = 12'h000;
    logic [3:0] levelEnable;
    logic [31:0] levelPriority;
    logic [5:0] serviceLevels;
    int orderErr;
    int error_cnt = 0;
    int total_checks = 0;
    dmacs_regs dmacs_regs_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busErr(busErr), .badDesc(badDesc), .blockEnd(blockEnd),
        .blockIrq(blockIrq), .blockSusp(blockSusp), .cmdSusp(cmdSusp), .evSusp(evSusp),
        .zeroCount(zeroCount), .chBusy(chBusy), .chPend(chPend), .chFetchErr(chFetchErr),
        .descValidClr(descValidClr), .writeBack(writeBack), .swTrigger(swTrigger),
        .controllerEnable(controllerEnable), .levelEnable(levelEnable),
        .levelPriority(levelPriority), .serviceLevels(serviceLevels),
        .runWhileHalted(runWhileHalted), .irq(irq));
    dmacs_far_model far_i (.ref_clk(ref_clk), .rst_n(rst_n), .busErr(busErr),
        .badDesc(badDesc), .blockEnd(blockEnd), .blockIrq(blockIrq), .blockSusp(blockSusp),
        .cmdSusp(cmdSusp), .evSusp(evSusp), .zeroCount(zeroCount), .chBusy(chBusy),
        .chPend(chPend), .chFetchErr(chFetchErr), .descValidClr(descValidClr),
        .writeBack(writeBack), .seenClr(seenClr), .orderErr(orderErr));
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) seenTrig <= seenTrig | swTrigger;
    task finish_test;
        if (orderErr != 0) error_cnt++;
        if (error_cnt == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
        begin
            error_cnt++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task t_ctrl;
        apb(1'b1, 12'h000, 32'h00000F06);
        chk(controllerEnable, 32'h1);
        chk(levelEnable, 32'hF);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h00000F06);
        apb(1'b1, 12'h008, 32'hFFFFFFFF);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h00003F0F);
        apb(1'b1, 12'h034, 32'h1);
        chk(runWhileHalted, 32'h1);
        apb(1'b1, 12'h038, 32'hFF);
        chk(serviceLevels, 32'h3F);
        apb(1'b1, 12'h050, 32'hFFFFFFFF);
        chk(levelPriority, 32'h8F8F8F8F);
        apb(1'b1, 12'h03C, 32'h1);
        chk(err, 32'h1);
        apb(1'b0, 12'h002, 32'h0);
        chk(err, 32'h1);
        apb(1'b1, 12'h090, 32'h1);
        chk(err, 32'h1);
    endtask
    task t_crc;
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h020, 32'h0);
        chk(err, 32'h0);
        apb(1'b0, 12'h030, 32'h0);
        chk(rd, 32'h00000002);
        apb(1'b1, 12'h010, 32'h01000000);
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, 32'h00001021);
        apb(1'b0, 12'h030, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h020, 32'h12345678);
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, 32'h12345678);
    endtask
    task t_events;
        logic [7:0] k [7];
        logic [2:0] e [7];
        k = '{8'h01, 8'h02, 8'h8C, 8'h04, 8'h14, 8'h20, 8'h40};
        e = '{3'h1, 3'h5, 3'h2, 3'h0, 3'h4, 3'h4, 3'h4};
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, 12'h0FC, i + 1);
            far_i.fire(k[i], i + 1);
            apb(1'b0, 12'h138, 32'h0);
            chk(rd, 32'(e[i]));
            apb(1'b1, 12'h138, 32'h7);
            apb(1'b0, 12'h138, 32'h0);
            chk(rd, 32'h0);
        end
        chk(seenClr, 32'h008);
    endtask
    task t_irq;
        apb(1'b1, 12'h0FC, 32'h3);
        far_i.fire(8'h01, 3);
        chk(irq, 32'h0);
        apb(1'b1, 12'h134, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk(irq, 32'h1);
        apb(1'b0, 12'h090, 32'h0);
        chk(rd, 32'h8);
        apb(1'b0, 12'h080, 32'h0);
        chk({rd[8], rd[3:0]}, 32'h13);
        apb(1'b1, 12'h0FC, 32'h4);
        apb(1'b0, 12'h138, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h138, 32'h7);
        apb(1'b1, 12'h0FC, 32'h3);
        apb(1'b1, 12'h138, 32'h0);
        apb(1'b0, 12'h138, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 12'h138, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk(irq, 32'h0);
    endtask
    task t_status;
        far_i.levels(12'h0A5, 12'h5A0, 12'h000);
        apb(1'b0, 12'h0A0, 32'h0);
        chk(rd, 32'h000000A5);
        apb(1'b0, 12'h0B0, 32'h0);
        chk(rd, 32'h000005A0);
        apb(1'b1, 12'h040, 32'hFFFFFFFF);
        repeat (2) @(posedge ref_clk);
        chk(seenTrig, 32'hFFF);
        chk(swTrigger, 32'h0);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        chk(controllerEnable, 32'h0);
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_ctrl();
        t_crc();
        t_events();
        t_irq();
        t_status();
        finish_test();
    end
endmodule
